// ---- rtl/srrc_top.sv ----
// command state machine for the synchronous rom burst-read port
`timescale 1ns/1ps

// Functional notes
// - decode only with static select low
// - same-cycle clock gate qualifies every command but read
// - five strobe patterns map to four commands
// - chip select high or spare patterns: nop
// - reset lands in standby, any command but stop accepted
// - mode set locks out commands three cycles
// - row address held until next activate
// - width sampled per read command
// - read latches column, burst ends itself
// - stop ends burst after latency; standby nop
// - activate in read no sooner than latency-1
// - reread in read no sooner than latency-1
// - low gate in read enters clock suspend
// - suspend holds while low, resumes when high
// - suspend keeps burst state, not power down
// - low gate, chip select high, in standby enters power down
// - high gate leaves power down, row kept
// - width high is 32 bit, low 16 bit
// - mode code fields: latency, order, length
// - reset mode: latency 5, sequential, length 4
module srrc_top (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // controller command pins
  input  srrc_pkg::srrc_cmd_s              pins,
  // rom array data
  input  wire logic [srrc_pkg::DATA_W-1:0] array_data,
  // array address and data out
  output logic [srrc_pkg::ADDR_W-1:0]      row_addr,
  output logic [srrc_pkg::COL_W-1:0]       col_addr,
  output logic [srrc_pkg::DATA_W-1:0]      dout,
  output logic                             dout_valid,
  output logic                             dout_wide,
  // status
  output srrc_pkg::srrc_state_e            state,
  output srrc_pkg::srrc_mode_s             mode,
  output logic                             int_clk_en
);

  // registered state
  srrc_pkg::srrc_state_e          state_r, state_nxt;
  srrc_pkg::srrc_mode_s           mode_r;
  logic [srrc_pkg::ADDR_W-1:0]    row_r;
  logic [srrc_pkg::COL_W-1:0]     col_r;
  logic                           cke_prev_r;
  logic [1:0]                     lock_r;
  logic [3:0]                     lat_r;
  logic [3:0]                     beat_r;
  logic                           wide_r;
  logic                           stop_pend_r;
  logic [3:0]                     stop_cnt_r;
  logic [srrc_pkg::DATA_W-1:0]    dout_r;
  logic                           dvalid_r;

  srrc_pkg::srrc_cmd_e cmd;

  // decoder: strobes to command
  srrc_decode u_dec (
    .pins     (pins),
    .cke_prev (cke_prev_r),
    .cmd      (cmd)
  );

  // qualifying gate and command strobes
  wire logic gate = pins.clk_gate;
  wire logic in_read  = (state_r == srrc_pkg::ST_READ);
  wire logic in_stdby = (state_r == srrc_pkg::ST_STANDBY);
  // commands count only in standby or read
  wire logic cmd_seen = in_read || in_stdby;
  wire logic cmd_ok  = cmd_seen && gate;
  wire logic is_act  = cmd_ok && (cmd == srrc_pkg::CMD_ACT);
  // a read may carry a low gate; its burst then starts suspended
  wire logic is_rd   = cmd_seen && (cmd == srrc_pkg::CMD_READ);
  // mode set in read is illegal and dropped
  wire logic is_mrs  = cmd_ok && in_stdby && (cmd == srrc_pkg::CMD_MRS);
  // stop only acts inside a burst
  wire logic is_stop = cmd_ok && in_read && (cmd == srrc_pkg::CMD_STOP);

  // mode code decode; reserved codes keep the old field
  wire logic [srrc_pkg::MODE_LAT_HI-srrc_pkg::MODE_LAT_LO:0] lat_code =
    pins.addr[srrc_pkg::MODE_LAT_HI:srrc_pkg::MODE_LAT_LO];
  wire logic [1:0] bl_code =
    pins.addr[srrc_pkg::MODE_BL_HI:srrc_pkg::MODE_BL_LO];
  logic [3:0] lat_new;
  logic [3:0] bl_new;

  // latency and length from the address code
  always_comb begin
    lat_new = mode_r.read_latency;
    bl_new  = mode_r.burst_length;
    if (lat_code == srrc_pkg::LAT_CODE_4) lat_new = srrc_pkg::LAT_4;
    if (lat_code == srrc_pkg::LAT_CODE_5) lat_new = srrc_pkg::LAT_RST;
    if (lat_code == srrc_pkg::LAT_CODE_6) lat_new = srrc_pkg::LAT_6;
    if (bl_code == srrc_pkg::BL_CODE_4) bl_new = srrc_pkg::BL_RST;
    if (bl_code == srrc_pkg::BL_CODE_8) bl_new = srrc_pkg::BL_8;
  end

  // burst end: all words out, or latency-delayed stop due
  // last word is the emit that finds one beat left, so all words go out
  wire logic last_beat = (beat_r == 4'h1);
  wire logic stop_due  = stop_pend_r && (stop_cnt_r == 4'h1);
  wire logic burst_out = (lat_r == 4'h0);
  wire logic emit      = in_read && burst_out && !stop_due && !is_rd;

  // next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      srrc_pkg::ST_STANDBY: begin
        if (!gate && pins.chip_sel_n)
          state_nxt = srrc_pkg::ST_POWER_DOWN;
        else if (is_mrs)
          state_nxt = srrc_pkg::ST_MRS_WAIT;
        else if (is_rd && !gate)
          state_nxt = srrc_pkg::ST_SUSPEND;
        else if (is_rd)
          state_nxt = srrc_pkg::ST_READ;
      end
      srrc_pkg::ST_MRS_WAIT: begin
        if (lock_r == 2'h1)
          state_nxt = srrc_pkg::ST_STANDBY;
      end
      srrc_pkg::ST_READ: begin
        if (!gate)
          state_nxt = srrc_pkg::ST_SUSPEND;
        else if (is_rd)
          state_nxt = srrc_pkg::ST_READ;
        else if (stop_due || (emit && last_beat))
          state_nxt = srrc_pkg::ST_STANDBY;
      end
      srrc_pkg::ST_SUSPEND: begin
        if (gate)
          state_nxt = srrc_pkg::ST_READ;
      end
      srrc_pkg::ST_POWER_DOWN: begin
        if (gate)
          state_nxt = srrc_pkg::ST_STANDBY;
      end
    endcase
  end

  // state, lock-out count and previous gate; reset gives standby
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r    <= srrc_pkg::ST_STANDBY;
      cke_prev_r <= 1'b1;
      lock_r     <= 2'h0;
    end else begin
      state_r    <= state_nxt;
      cke_prev_r <= gate;
      lock_r     <= is_mrs ? srrc_pkg::MRS_LOCK_CYC :
                    (lock_r != 2'h0) ? lock_r - 2'h1 : 2'h0;
    end
  end

  // mode register with power-up defaults
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= '{srrc_pkg::LAT_RST, srrc_pkg::ORDER_RST, srrc_pkg::BL_RST};
    end else if (is_mrs) begin
      mode_r <= '{lat_new, pins.addr[srrc_pkg::MODE_ORDER], bl_new};
    end
  end

  // row address survives every state, power down included
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      row_r <= '0;
    end else if (is_act) begin
      row_r <= pins.addr;
    end
  end

  // burst progress: frozen whenever not in the read state, except a read loads it from standby
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      col_r  <= '0;
      wide_r <= 1'b0;
      lat_r  <= 4'h0;
      beat_r <= 4'h0;
    end else if (is_rd) begin
      col_r  <= pins.addr[srrc_pkg::COL_W-1:0];
      wide_r <= pins.width_sel;
      lat_r  <= mode_r.read_latency - 4'h1;
      beat_r <= mode_r.burst_length;
    end else if (in_read && gate) begin
      if (!burst_out)
        lat_r <= lat_r - 4'h1;
      else if (emit) begin
        col_r  <= col_r + 9'h001;
        beat_r <= beat_r - 4'h1;
      end
    end
  end

  // delayed stop: burst ends read-latency cycles after the stop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stop_pend_r <= 1'b0;
      stop_cnt_r  <= 4'h0;
    end else if (is_rd || state_nxt == srrc_pkg::ST_STANDBY) begin
      stop_pend_r <= 1'b0;
      stop_cnt_r  <= 4'h0;
    end else if (is_stop && !stop_pend_r) begin
      stop_pend_r <= 1'b1;
      stop_cnt_r  <= mode_r.read_latency;
    end else if (stop_pend_r && in_read && gate) begin
      stop_cnt_r  <= stop_cnt_r - 4'h1;
    end
  end

  // data out register: one word per active cycle of the burst
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dout_r   <= '0;
      dvalid_r <= 1'b0;
    end else if (in_read && gate) begin
      dvalid_r <= emit;
      // width is the one latched with the read, not the live pin
      dout_r   <= wide_r ? array_data :
                  {16'h0000, array_data[15:0]};
    end else if (!in_read && state_r != srrc_pkg::ST_SUSPEND) begin
      dvalid_r <= 1'b0;
    end
  end

  // registered outputs
  logic int_clk_en_r;
  logic wide_q_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      int_clk_en_r <= 1'b1;
      wide_q_r     <= 1'b0;
    end else begin
      int_clk_en_r <= (state_nxt != srrc_pkg::ST_SUSPEND) &&
                      (state_nxt != srrc_pkg::ST_POWER_DOWN);
      wide_q_r     <= wide_r;
    end
  end

  assign row_addr   = row_r;
  assign col_addr   = col_r;
  assign dout       = dout_r;
  assign dout_valid = dvalid_r;
  assign dout_wide  = wide_q_r;
  assign state      = state_r;
  assign mode       = mode_r;
  assign int_clk_en = int_clk_en_r;

endmodule : srrc_top

// ---- rtl/srrc_pkg.sv ----
// package: constants and types for the synchronous rom read command block
package srrc_pkg;

  // address and data widths
  localparam int ADDR_W = 13;
  localparam int COL_W  = 9;
  localparam int DATA_W = 32;

  // mode register field positions
  localparam int MODE_LAT_HI = 5;
  localparam int MODE_LAT_LO = 3;
  localparam int MODE_ORDER  = 2;
  localparam int MODE_BL_HI  = 1;
  localparam int MODE_BL_LO  = 0;

  // read latency and burst length codes
  localparam logic [2:0] LAT_CODE_4 = 3'h3;
  localparam logic [2:0] LAT_CODE_5 = 3'h4;
  localparam logic [2:0] LAT_CODE_6 = 3'h5;
  localparam logic [1:0] BL_CODE_4  = 2'h1;
  localparam logic [1:0] BL_CODE_8  = 2'h2;

  // values after reset
  localparam logic [3:0] LAT_RST   = 4'h5;
  localparam logic [3:0] BL_RST    = 4'h4;
  localparam logic       ORDER_RST = 1'b0;

  // cycle counts
  localparam logic [1:0] MRS_LOCK_CYC = 2'h3;
  localparam logic [3:0] LAT_4 = 4'h4;
  localparam logic [3:0] LAT_6 = 4'h6;
  localparam logic [3:0] BL_8  = 4'h8;

  // device states
  typedef enum logic [2:0] {
    ST_STANDBY, ST_MRS_WAIT, ST_READ, ST_SUSPEND, ST_POWER_DOWN
  } srrc_state_e;

  // decoded command
  typedef enum logic [2:0] {
    CMD_NOP, CMD_MRS, CMD_ACT, CMD_READ, CMD_STOP
  } srrc_cmd_e;

  // command pins from the controller
  typedef struct packed {
    logic              chip_sel_n;
    logic              row_strobe_n;
    logic              col_strobe_n;
    logic              mode_strobe_n;
    logic              clk_gate;
    logic              width_sel;
    logic              static_op_select;
    logic [ADDR_W-1:0] addr;
  } srrc_cmd_s;

  // mode register contents
  typedef struct packed {
    logic [3:0] read_latency;
    logic       interleave;
    logic [3:0] burst_length;
  } srrc_mode_s;

endpackage : srrc_pkg

// ---- rtl/srrc_decode.sv ----
// command decoder for the synchronous rom read port
`timescale 1ns/1ps

module srrc_decode (
  // command pins
  input  srrc_pkg::srrc_cmd_s pins,
  input  wire logic           cke_prev,
  // decoded command
  output srrc_pkg::srrc_cmd_e cmd
);

  // strobes packed as row/column/mode
  wire logic [2:0] rcm;
  wire logic       live;

  assign rcm  = {pins.row_strobe_n, pins.col_strobe_n, pins.mode_strobe_n};
  // pull-down makes an open static select read low
  assign live = !pins.static_op_select && !pins.chip_sel_n && cke_prev;

  // unlisted patterns fall to no-operation
  always_comb begin
    cmd = srrc_pkg::CMD_NOP;
    if (live) begin
      unique case (rcm)
        3'h0:    cmd = srrc_pkg::CMD_MRS;
        3'h3:    cmd = srrc_pkg::CMD_ACT;
        3'h5:    cmd = srrc_pkg::CMD_READ;
        3'h6:    cmd = srrc_pkg::CMD_STOP;
        3'h2:    cmd = srrc_pkg::CMD_STOP;
        default: cmd = srrc_pkg::CMD_NOP;
      endcase
    end
  end

endmodule : srrc_decode

// ---- bench/srrc_props.sv ----
// assertion checker for the rom read command state machine
`timescale 1ns/1ps

module srrc_props (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        nrst,
  // controller pins and array data
  input srrc_pkg::srrc_cmd_s              pins,
  input wire logic [srrc_pkg::DATA_W-1:0] array_data,
  // device outputs
  input wire logic [srrc_pkg::ADDR_W-1:0] row_addr,
  input wire logic [srrc_pkg::COL_W-1:0]  col_addr,
  input wire logic [srrc_pkg::DATA_W-1:0] dout,
  input wire logic                        dout_valid,
  input wire logic                        dout_wide,
  input srrc_pkg::srrc_state_e            state,
  input srrc_pkg::srrc_mode_s             mode,
  input wire logic                        int_clk_en
);
  logic gate_r;
  // previous gate sample; resets high so the first command qualifies
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) gate_r <= 1'h1;
    else gate_r <= pins.clk_gate;
  end
  // state and command decode kept apart from the design's own decoder
  wire sb = state == srrc_pkg::ST_STANDBY;
  wire rs = state == srrc_pkg::ST_READ;
  wire su = state == srrc_pkg::ST_SUSPEND;
  wire pd = state == srrc_pkg::ST_POWER_DOWN;
  wire mw = state == srrc_pkg::ST_MRS_WAIT;
  wire [2:0] rcm = {pins.row_strobe_n, pins.col_strobe_n, pins.mode_strobe_n};
  wire ok = !pins.static_op_select && pins.clk_gate && gate_r;
  wire live = ok && !pins.chip_sel_n && (sb || rs);
  wire act = live && rcm == 3'h3;
  wire rd = live && rcm == 3'h5 && sb;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_mrs_lock: assert property ($rose(mw) |-> mw[*3] ##1 sb)
    else $error("mode set lockout length wrong");
  chk_row_load: assert property (act |=> row_addr == $past(pins.addr))
    else $error("row not latched");
  chk_row_keep: assert property (!act |=> $stable(row_addr))
    else $error("row changed without activate");
  chk_read_start: assert property (rd |=> (rs && !dout_valid) ##1
    (!dout_valid)[*3])
    else $error("read start wrong");
  chk_pd_entry: assert property (sb && ok == 1'h0 && pins.chip_sel_n
    && !pins.clk_gate && gate_r && !pins.static_op_select
    |=> pd && !int_clk_en)
    else $error("power down not entered");
  chk_pd_stay_exit: assert property (pd |=> $past(pins.clk_gate) ? sb
    : pd && !int_clk_en)
    else $error("power down exit wrong");
  chk_susp_entry: assert property (rs && !pins.clk_gate
    |=> su && !int_clk_en)
    else $error("suspend not entered");
  chk_susp_freeze: assert property (su && !pins.clk_gate
    |=> su && $stable(col_addr))
    else $error("burst moved in suspend");
  chk_susp_exit: assert property (su && pins.clk_gate |=> rs)
    else $error("suspend exit wrong");
  chk_nop_stay: assert property (sb && pins.clk_gate && (pins.chip_sel_n
    || pins.static_op_select || rcm inside {3'h1, 3'h2, 3'h4, 3'h6, 3'h7})
    |=> sb)
    else $error("no-operation left standby");
  cover property (mw);
  cover property (su);
  cover property (pd ##1 sb);
  cover property (rs && act);
  cover property (rs && live && rcm == 3'h5);
endmodule : srrc_props

bind srrc_top srrc_props u_props (.clk, .nrst, .pins, .array_data,
  .row_addr, .col_addr, .dout, .dout_valid, .dout_wide, .state, .mode,
  .int_clk_en);

// ---- bench/srrc_ctrl_model.sv ----
// memory controller model driving the rom command pins
`timescale 1ns/1ps

module srrc_ctrl_model (
  // clock
  input wire logic     clk,
  // command pins toward the rom
  output srrc_pkg::srrc_cmd_s pins
);
  // idle pins at time zero: deselected, gate running
  initial begin
    pins = '0;
    pins.chip_sel_n = 1'h1;
    pins.clk_gate = 1'h1;
  end
  // deselected cycles; address, width and row and column strobes flip so stale values never pass
  task automatic idle(input int n, input logic g);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      pins.chip_sel_n <= 1'h1;
      pins.clk_gate <= g;
      pins.static_op_select <= 1'h0;
      pins.addr <= ~pins.addr;
      pins.width_sel <= ~pins.width_sel;
      pins.row_strobe_n <= ~pins.row_strobe_n;
      pins.col_strobe_n <= ~pins.col_strobe_n;
    end
  endtask : idle
  // one command cycle with gate high this and last cycle
  task automatic cmd(input logic [2:0] rcm, input logic [12:0] a,
                     input logic w, input logic s);
    @(posedge clk);
    pins.chip_sel_n <= 1'h0;
    {pins.row_strobe_n, pins.col_strobe_n, pins.mode_strobe_n} <= rcm;
    pins.clk_gate <= 1'h1;
    pins.addr <= a;
    pins.width_sel <= w;
    pins.static_op_select <= s;
    if (rcm == 3'h0) idle(3, 1'h1);
  endtask : cmd
endmodule : srrc_ctrl_model

// ---- bench/srrc_top_tb.sv ----
// self-checking bench for the rom read command state machine
`timescale 1ns/1ps

module srrc_top_tb;
  logic                        clk = 1'h0;
  logic                        nrst = 1'h0;
  int                          err_count = 0;
  int                          compares = 0;
  int                          cyc = 0;
  srrc_pkg::srrc_cmd_s         pins;
  logic [12:0]                 row_addr;
  logic [8:0]                  col_addr;
  logic [31:0]                 dout;
  logic                        dout_valid;
  logic                        dout_wide;
  srrc_pkg::srrc_state_e       state;
  srrc_pkg::srrc_mode_s        mode;
  logic                        int_clk_en;
  // array word tags row and column so misrouting shows
  wire [31:0] array_data = {row_addr, 10'h0, col_addr};

  always #50 clk = ~clk;

  srrc_ctrl_model ctl (.clk, .pins);
  srrc_top uut (.clk, .nrst, .pins, .array_data, .row_addr, .col_addr,
    .dout, .dout_valid, .dout_wide, .state, .mode, .int_clk_en);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  // hang guard well above the planned run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      $display("Error at %0t: timeout", $time);
      test_done();
    end
  end

  // activate, read, then at cycle sp: stop (sc 6/2), suspend (sc 0),
  // reread (sc 5) or activate of the inverted row (sc 3); sc 7 plain
  task automatic t_burst(input logic [12:0] r, input logic [8:0] c,
    input logic w, input int lat, input int bl, input int sp,
    input logic [2:0] sc);
    int words;
    int first;
    logic [12:0] ex_r;
    logic [12:0] cmd_a;
    words = 0;
    first = 0;
    ex_r = (sc == 3'h3) ? ~r : r;
    cmd_a = (sc == 3'h3) ? ex_r : {4'h0, c};
    ctl.cmd(3'h3, r, 1'h0, 1'h0);
    ctl.cmd(3'h5, {4'h0, c}, w, 1'h0);
    for (int n = 1; n < 30; n++) begin
      if (sc != 3'h0 && sc != 3'h7 && n == sp)
        ctl.cmd(sc, cmd_a, w, 1'h0);
      else
        ctl.idle(1, !(sc == 3'h0 && n >= sp && n < sp + 3));
      #1;
      if (sc == 3'h0 && n == sp + 2) begin
        chk(state, srrc_pkg::ST_SUSPEND);
        chk(int_clk_en, 1'h0);
      end
      if (dout_valid === 1'h1) begin
        if (words == 0) first = n;
        chk(dout[8:0], 9'(c + words));
        words++;
        chk(dout[31:19], w ? ex_r : 13'h0);
        chk(dout_wide, w);
      end
    end
    chk(state, srrc_pkg::ST_STANDBY);
    if (sc == 3'h6 || sc == 3'h2) chk(words < bl, 1'h1);
    else chk(words, bl);
    // pass n sees the edge n-1 after the read; a suspend costs four edges
    if (sc == 3'h7 || sc == 3'h3) chk(first, lat + 1);
    if (sc == 3'h5) chk(first, sp + lat + 1);
    if (sc == 3'h0) chk(first, lat + 5);
  endtask : t_burst

  // every latency code, both lengths, interleave, then stop, suspend, reread and activate
  task automatic t_mode;
    logic [2:0] scs[5];
    logic [1:0] blc;
    scs = '{3'h6, 3'h2, 3'h0, 3'h5, 3'h3};
    for (int i = 0; i < 3; i++) begin
      blc = (i == 1) ? 2'h2 : 2'h1;
      ctl.cmd(3'h0, {7'h0, 3'(i + 3), i == 1, blc}, 1'h0, 1'h0);
      #1;
      chk(mode, {4'(i + 4), i == 1, 4'(blc * 4)});
      t_burst(13'h0a5a, 9'h020, i[0], i + 4, blc * 4, 0, 3'h7);
    end
    ctl.cmd(3'h0, 13'h001a, 1'h0, 1'h0);
    // cycle 3 is latency-1 after the read, the earliest legal reread
    foreach (scs[k]) begin
      t_burst(13'h1111, 9'h040, 1'h1, 4, 8, 3, scs[k]);
    end
  endtask : t_mode

  // nop patterns, stops in standby, static select, then power down
  task automatic t_misc;
    logic [2:0] nops[5];
    nops = '{3'h1, 3'h4, 3'h7, 3'h6, 3'h2};
    ctl.cmd(3'h3, 13'h0abc, 1'h0, 1'h0);
    foreach (nops[k]) ctl.cmd(nops[k], 13'h1555, 1'h0, 1'h0);
    ctl.cmd(3'h3, 13'h1fff, 1'h0, 1'h1);
    ctl.idle(2, 1'h1);
    #1;
    chk(row_addr, 13'h0abc);
    chk(state, srrc_pkg::ST_STANDBY);
    ctl.idle(3, 1'h0);
    #1;
    chk(state, srrc_pkg::ST_POWER_DOWN);
    chk(int_clk_en, 1'h0);
    ctl.idle(2, 1'h1);
    #1;
    chk(state, srrc_pkg::ST_STANDBY);
    chk(row_addr, 13'h0abc);
  endtask : t_misc

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    #1;
    chk(mode, {srrc_pkg::LAT_RST, srrc_pkg::ORDER_RST, srrc_pkg::BL_RST});
    chk(state, srrc_pkg::ST_STANDBY);
    t_burst(13'h1234, 9'h010, 1'h1, 5, 4, 0, 3'h7);
    t_burst(13'h0f0f, 9'h1f0, 1'h0, 5, 4, 0, 3'h7);
    t_mode();
    t_misc();
    test_done();
  end
endmodule : srrc_top_tb
